// File: design/gstc_pkg.sv
// Constants, register map and field layouts of the gated sixteen-bit timer.
// Assumes an APB master with 32-bit data; each byte register sits in one word.
package gstc_pkg;
   // ----------------------------------------------------------------------
   // Register map: printed offsets are indices, byte address is four times.
   // ----------------------------------------------------------------------
   localparam int unsigned ADDR_W = 12;
   localparam logic [11:0] IDX_CNT_LO = 12'h30c;
   localparam logic [11:0] IDX_CNT_HI = 12'h30d;
   localparam logic [11:0] IDX_TCTL = 12'h30e;
   localparam logic [11:0] IDX_GCTL = 12'h30f;
   localparam logic [11:0] IDX_GSRC = 12'h310;
   localparam logic [11:0] IDX_CSRC = 12'h311;
   localparam logic [11:0] IDX_STAT = 12'h318;
   // ----------------------------------------------------------------------
   // Field positions and source codes.
   // ----------------------------------------------------------------------
   localparam int unsigned STAT_ROLL_BIT = 0;
   localparam int unsigned STAT_GEVT_BIT = 1;
   localparam logic [4:0] CS_PIN = 5'h00;
   localparam logic [4:0] CS_FOSC4 = 5'h01;
   localparam logic [4:0] CS_FOSC = 5'h02;
   localparam logic [4:0] CS_OVF_T1 = 5'h0c;
   localparam logic [4:0] CS_OVF_T3 = 5'h0d;
   localparam logic [4:0] CS_LAST = 5'h11;
   localparam logic [4:0] GS_OVF_T1 = 5'h02;
   localparam logic [4:0] GS_OVF_T3 = 5'h04;
   localparam logic [4:0] GS_LAST = 5'h18;
   localparam logic [1:0] PS_DIV1 = 2'h0;
   localparam logic [1:0] PS_DIV2 = 2'h1;
   localparam logic [1:0] PS_DIV4 = 2'h2;
   localparam logic [1:0] PS_DIV8 = 2'h3;
   localparam logic [1:0] QUAD_LAST = 2'h3;
   localparam logic [15:0] CNT_MAX = 16'hffff;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic [4:0] SRC_RESET = 5'h00;
   // ----------------------------------------------------------------------
   // Field groups.
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [1:0] prescale_select;
      logic sync_bypass;
      logic wide_access_enable;
      logic timer_on;
   } gstc_tctl_s;
   typedef struct packed {
      logic gate_enable;
      logic gate_polarity;
      logic gate_toggle_mode;
      logic gate_single_pulse_mode;
   } gstc_gctl_s;
   localparam gstc_tctl_s TCTL_RESET = '{2'h0, 1'b0, 1'b0, 1'b0};
   localparam gstc_gctl_s GCTL_RESET = '{1'b0, 1'b0, 1'b0, 1'b0};
   typedef enum logic [1:0] {
      SP_IDLE = 2'b00,
      SP_ARMED = 2'b01,
      SP_RUN = 2'b10
   } gstc_sp_e;
endpackage

// File: design/gstc_timer.sv
// Sixteen-bit gated up-counter with prescaler, source selectors and APB registers.
// Assumes clock and gate sources arrive asynchronously; presetn is power-on reset.
//
// Functional notes
// - Prescale code 11 divides by 8, 10 by 4, 01 by 2, 00 none.
// - System clock and its quarter ignore the sync bit and are used directly.
// - Other sources: sync bit 1 bypasses alignment, 0 aligns to system clock.
// - Wide access bit makes the counter one 16-bit access, else two bytes.
// - Wide mode: low read latches high buffer; low write loads high from buffer.
// - Enabled with gate enable: gate decides counting; disabled: nothing counts.
// - Enabled without gate enable: count every prescaled edge.
// - Polarity 1 counts while gate high, 0 while gate low.
// - Toggle mode passes the gate through a flop toggling on rising edges.
// - Toggle mode off forces and holds the toggle flop clear.
// - Single pulse mode hands the gate to the acquisition logic.
// - Go/done reads 1 while armed or acquiring, 0 when done or idle.
// - Clearing single pulse mode clears go/done.
// - Counting starts on next gate edge; trailing edge clears go/done, blocks more.
// - Gate level view shows the gate feeding the counter, whatever gate enable.
// - Five-bit clock selector picks the source; codes above 10001 are reserved.
// - Clock selector resets to 00000 on power-on reset only.
// - Five-bit gate selector picks the gate; codes above 11000 are reserved.
// - Counter is reached as a high byte 15:8 and low byte 7:0.
// - Counter clears only on power-on reset.
// - Counter rolls from maximum to zero and sets the rollover flag.
// - Falling gate level sets the gate event flag, even with gate disabled.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module gstc_timer
   import gstc_pkg::*;
#(
   parameter bit FIRST_INSTANCE = 1'b1,
   parameter int unsigned N_CLK_SRC = 18,
   parameter int unsigned N_GATE_SRC = 25
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [N_CLK_SRC-1:0] clk_src_in,
   input wire logic [N_GATE_SRC-1:0] gate_src_in,
   output logic overflow_out,
   output logic rollover_flag,
   output logic gate_event_flag
);
   // ----------------------------------------------------------------------
   // Helpers.
   // ----------------------------------------------------------------------
   function automatic logic [ADDR_W-1:0] byte_addr(input logic [11:0] idx);
      byte_addr = ADDR_W'({idx, 2'b00});
   endfunction

   function automatic logic [2:0] ps_mask(input logic [1:0] code);
      case (code)
         PS_DIV1: ps_mask = 3'h0;
         PS_DIV2: ps_mask = 3'h1;
         PS_DIV4: ps_mask = 3'h3;
         PS_DIV8: ps_mask = 3'h7;
         default: ps_mask = 3'h0;
      endcase
   endfunction

   // ----------------------------------------------------------------------
   // Registers and state.
   // ----------------------------------------------------------------------
   gstc_tctl_s tctl_reg;
   gstc_gctl_s gctl_reg;
   gstc_sp_e sp_reg;
   logic [4:0] cs_reg;
   logic [4:0] gss_reg;
   logic [15:0] cnt_reg;
   logic [7:0] hbuf_reg;
   logic [2:0] ps_reg;
   logic [1:0] quad_reg;
   logic pend_reg;
   logic [2:0] csync_reg;
   logic [2:0] gsync_reg;
   logic clvl_reg;
   logic clvl_d_reg;
   logic glvl_reg;
   logic glvl_d_reg;
   logic tff_reg;
   logic act_d_reg;
   logic gate_level_view_reg;

   // ----------------------------------------------------------------------
   // APB access decode.
   // ----------------------------------------------------------------------
   logic cap;
   logic done;
   logic hit;
   logic [7:0] rd_data;
   logic [7:0] wd;
   logic wr;
   logic wr_lo;
   logic wr_hi;
   logic rd_lo;

   assign cap = psel && penable && !pready;
   assign done = psel && penable && pready;
   assign wd = pwdata[7:0];
   assign wr = done && pwrite && pstrb[0] && hit;
   assign wr_lo = wr && (paddr == byte_addr(IDX_CNT_LO));
   assign wr_hi = wr && (paddr == byte_addr(IDX_CNT_HI));
   assign rd_lo = cap && !pwrite && (paddr == byte_addr(IDX_CNT_LO));

   // Unused bit positions are constant zero here and never stored.
   always_comb
   begin
      hit = 1'b1;
      rd_data = 8'h00;
      case (paddr)
         byte_addr(IDX_CNT_LO): rd_data = cnt_reg[7:0];
         byte_addr(IDX_CNT_HI): rd_data = tctl_reg.wide_access_enable ?
            hbuf_reg : cnt_reg[15:8];
         byte_addr(IDX_TCTL): rd_data = {2'b00, tctl_reg.prescale_select, 1'b0,
            tctl_reg.sync_bypass, tctl_reg.wide_access_enable, tctl_reg.timer_on};
         byte_addr(IDX_GCTL): rd_data = {gctl_reg, sp_reg != SP_IDLE, gate_level_view_reg,
            2'b00};
         byte_addr(IDX_GSRC): rd_data = {3'b000, gss_reg};
         byte_addr(IDX_CSRC): rd_data = {3'b000, cs_reg};
         byte_addr(IDX_STAT): rd_data = {6'b000000, gate_event_flag, rollover_flag};
         default: hit = 1'b0;
      endcase
   end

   // One wait state gives time to register the read data.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= cap;
         prdata <= (cap && !pwrite) ? {24'h000000, rd_data} : 32'h0000_0000;
         pslverr <= cap && !hit;
      end
   end

   // ----------------------------------------------------------------------
   // Control registers; only power-on reset touches them.
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tctl_reg <= TCTL_RESET;
         gctl_reg <= GCTL_RESET;
         gss_reg <= SRC_RESET;
         cs_reg <= SRC_RESET;
      end
      else if (wr)
      begin
         if (paddr == byte_addr(IDX_TCTL))
            tctl_reg <= '{wd[5:4], wd[2], wd[1], wd[0]};
         if (paddr == byte_addr(IDX_GCTL))
            gctl_reg <= wd[7:4];
         if (paddr == byte_addr(IDX_GSRC))
            gss_reg <= wd[4:0];
         if (paddr == byte_addr(IDX_CSRC))
            cs_reg <= wd[4:0];
      end
   end

   // ----------------------------------------------------------------------
   // Clock source selection and synchronisation.
   // ----------------------------------------------------------------------
   logic cs_valid;
   logic gs_valid;
   logic clk_rise;
   logic cnt_edge;

   // The code that would point at this instance's own overflow is reserved.
   assign cs_valid = (cs_reg <= CS_LAST) &&
      (cs_reg != (FIRST_INSTANCE ? CS_OVF_T1 : CS_OVF_T3));
   assign gs_valid = (gss_reg <= GS_LAST) &&
      (gss_reg != (FIRST_INSTANCE ? GS_OVF_T1 : GS_OVF_T3));

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         csync_reg <= 3'h0;
         clvl_reg <= 1'b0;
         clvl_d_reg <= 1'b0;
      end
      else
      begin
         csync_reg <= {csync_reg[1:0], cs_valid && clk_src_in[cs_reg]};
         if (csync_reg[1] == csync_reg[2])
            clvl_reg <= csync_reg[2];
         clvl_d_reg <= clvl_reg;
      end
   end

   assign clk_rise = clvl_reg && !clvl_d_reg;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         quad_reg <= 2'h0;
      else
         quad_reg <= quad_reg + 2'h1;
   end

   // Aligned mode holds an edge until the next quarter-rate tick.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pend_reg <= 1'b0;
      else
         pend_reg <= (pend_reg || clk_rise) && (quad_reg != QUAD_LAST);
   end

   always_comb
   begin
      case (cs_reg)
         CS_FOSC: cnt_edge = 1'b1;
         CS_FOSC4: cnt_edge = quad_reg == QUAD_LAST;
         default:
         begin
            if (!cs_valid)
               cnt_edge = 1'b0;
            else if (tctl_reg.sync_bypass)
               cnt_edge = clk_rise;
            else
               cnt_edge = (pend_reg || clk_rise) && (quad_reg == QUAD_LAST);
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // Gate path: toggle, polarity, single pulse.
   // ----------------------------------------------------------------------
   logic g_rise;
   logic tsig;
   logic act;
   logic act_rise;
   logic act_fall;
   logic gate_val;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gsync_reg <= 3'h0;
         glvl_reg <= 1'b0;
         glvl_d_reg <= 1'b0;
      end
      else
      begin
         gsync_reg <= {gsync_reg[1:0], gs_valid && gate_src_in[gss_reg]};
         if (gsync_reg[1] == gsync_reg[2])
            glvl_reg <= gsync_reg[2];
         glvl_d_reg <= glvl_reg;
      end
   end

   assign g_rise = glvl_reg && !glvl_d_reg;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tff_reg <= 1'b0;
      else if (!gctl_reg.gate_toggle_mode)
         tff_reg <= 1'b0;
      else if (g_rise)
         tff_reg <= !tff_reg;
   end

   assign tsig = gctl_reg.gate_toggle_mode ? tff_reg : glvl_reg;
   assign act = gctl_reg.gate_polarity ? tsig : !tsig;
   assign act_rise = act && !act_d_reg;
   assign act_fall = !act && act_d_reg;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         act_d_reg <= 1'b0;
      else
         act_d_reg <= act;
   end

   // Software arms an acquisition; hardware ends it on the trailing edge.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sp_reg <= SP_IDLE;
      else if (wr && (paddr == byte_addr(IDX_GCTL)))
      begin
         if (!wd[4])
            sp_reg <= SP_IDLE;
         else if (!wd[3])
            sp_reg <= SP_IDLE;
         else if (sp_reg == SP_IDLE)
            sp_reg <= SP_ARMED;
      end
      else if (!gctl_reg.gate_single_pulse_mode)
         sp_reg <= SP_IDLE;
      else
      begin
         case (sp_reg)
            SP_ARMED: if (act_rise) sp_reg <= SP_RUN;
            SP_RUN: if (act_fall) sp_reg <= SP_IDLE;
            default: sp_reg <= sp_reg;
         endcase
      end
   end

   // Idle blocks all further gate events until the next arm.
   assign gate_val = gctl_reg.gate_single_pulse_mode ?
      (act && ((sp_reg == SP_RUN) || ((sp_reg == SP_ARMED) && act_rise))) : act;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         gate_level_view_reg <= 1'b0;
      else
         gate_level_view_reg <= gate_val;
   end

   // ----------------------------------------------------------------------
   // Prescaler and counter.
   // ----------------------------------------------------------------------
   logic count_en;
   logic ps_tick;

   assign count_en = tctl_reg.timer_on &&
      (!gctl_reg.gate_enable || gate_level_view_reg);
   assign ps_tick = cnt_edge && count_en &&
      ((ps_reg & ps_mask(tctl_reg.prescale_select)) ==
      ps_mask(tctl_reg.prescale_select));

   // Only a low-byte write restarts the prescaler.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ps_reg <= 3'h0;
      else if (wr_lo)
         ps_reg <= 3'h0;
      else if (ps_tick)
         ps_reg <= 3'h0;
      else if (cnt_edge && count_en)
         ps_reg <= ps_reg + 3'h1;
   end

   // A software write beats a count in the same cycle.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt_reg <= CNT_RESET;
      else if (wr_lo)
         cnt_reg <= tctl_reg.wide_access_enable ? {hbuf_reg, wd} :
            {cnt_reg[15:8], wd};
      else if (wr_hi && !tctl_reg.wide_access_enable)
         cnt_reg <= {wd, cnt_reg[7:0]};
      else if (ps_tick)
         cnt_reg <= cnt_reg + 16'h0001;
   end

   // The buffer is the staging byte for wide writes and the snapshot for reads.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         hbuf_reg <= 8'h00;
      else if (rd_lo && tctl_reg.wide_access_enable)
         hbuf_reg <= cnt_reg[15:8];
      else if (wr_hi && tctl_reg.wide_access_enable)
         hbuf_reg <= wd;
   end

   // ----------------------------------------------------------------------
   // Event flags; a new event wins over a clear in the same cycle.
   // ----------------------------------------------------------------------
   logic roll_evt;
   logic stat_wr;

   assign roll_evt = ps_tick && !wr_lo && !(wr_hi && !tctl_reg.wide_access_enable) &&
      (cnt_reg == CNT_MAX);
   assign stat_wr = wr && (paddr == byte_addr(IDX_STAT));

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rollover_flag <= 1'b0;
      else
         rollover_flag <= roll_evt ||
            (rollover_flag && !(stat_wr && wd[STAT_ROLL_BIT]));
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         gate_event_flag <= 1'b0;
      else
         gate_event_flag <= (gate_level_view_reg && !gate_val) ||
            (gate_event_flag && !(stat_wr && wd[STAT_GEVT_BIT]));
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         overflow_out <= 1'b0;
      else
         overflow_out <= roll_evt;
   end
endmodule
`default_nettype wire

// File: bench/gstc_timer_properties.sv
// Concurrent checks on the APB answer and the sticky event flags of the timer.
// Assumes it is bound to gstc_timer and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module gstc_timer_chk
   import gstc_pkg::*;
#(
   parameter int unsigned N_CLK_SRC = 18,
   parameter int unsigned N_GATE_SRC = 25
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [N_CLK_SRC-1:0] clk_src_in,
   input wire logic [N_GATE_SRC-1:0] gate_src_in,
   input wire logic overflow_out,
   input wire logic rollover_flag,
   input wire logic gate_event_flag
);
   // --------------------
   // Helpers
   // --------------------
   logic mapped;
   logic clr;
   assign mapped = paddr inside {12'hc30, 12'hc34, 12'hc38, 12'hc3c, 12'hc40, 12'hc44, 12'hc60};
   assign clr = psel && penable && pready && pwrite && pstrb[0] && paddr == 12'hc60;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_wait_state;
      psel && penable && !pready |=> pready;
   endproperty
   a_wait_state: assert property (p_wait_state) else $error("no ready after one wait");
   property p_err_map;
      psel && !penable |=> ##1 pready && (pslverr == !$past(mapped, 2));
   endproperty
   a_err_map: assert property (p_err_map) else $error("error answer wrong");
   property p_rdata_idle;
      !pready || pwrite |-> prdata == 32'h0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read");
   property p_rdata_upper;
      pready |-> prdata[31:8] == 24'h0;
   endproperty
   a_rdata_upper: assert property (p_rdata_upper) else $error("upper read bits set");
   property p_ovf_flag;
      overflow_out |-> ##[0:1] rollover_flag;
   endproperty
   a_ovf_flag: assert property (p_ovf_flag) else $error("rollover flag not set");
   property p_roll_cause;
      $rose(rollover_flag) |-> overflow_out || $past(overflow_out);
   endproperty
   a_roll_cause: assert property (p_roll_cause) else $error("rollover flag without wrap");
   property p_roll_hold;
      rollover_flag && !(clr && pwdata[STAT_ROLL_BIT]) |=> rollover_flag;
   endproperty
   a_roll_hold: assert property (p_roll_hold) else $error("rollover flag lost");
   property p_gevt_hold;
      gate_event_flag && !(clr && pwdata[STAT_GEVT_BIT]) |=> gate_event_flag;
   endproperty
   a_gevt_hold: assert property (p_gevt_hold) else $error("gate event flag lost");
   c_rollover: cover property (overflow_out);
   c_gate_event: cover property ($rose(gate_event_flag));
   c_refused: cover property (pready && pslverr);
endmodule
bind gstc_timer gstc_timer_chk #(.N_CLK_SRC(N_CLK_SRC), .N_GATE_SRC(N_GATE_SRC)) i_gstc_timer_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .clk_src_in(clk_src_in), .gate_src_in(gate_src_in),
   .overflow_out(overflow_out), .rollover_flag(rollover_flag),
   .gate_event_flag(gate_event_flag));
`default_nettype wire

// File: bench/gstc_src_model.sv
// Far side of the timer: the clock and gate sources it selects from.
// Assumes the bench asks for bursts of clock edges and sets the gate level.
`timescale 1ns/1ps
`default_nettype none
module gstc_src_model
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [4:0] clk_code,
   input wire logic [4:0] gate_code,
   input wire logic gate_level,
   input wire logic start,
   input wire logic [7:0] n_edges,
   output logic busy,
   output logic [17:0] clk_src_in,
   output logic [24:0] gate_src_in
);
   // --------------------
   // Edge bursts
   // --------------------
   logic [7:0] left_reg;
   logic [2:0] ph_reg;
   logic [24:0] noise_reg;
   // Lines not selected follow a pseudo-random pattern stepped every cycle, so a wrong selector shows up as extra counts.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         left_reg <= 8'h00;
         ph_reg <= 3'h0;
         noise_reg <= 25'h1;
      end
      else
      begin
         noise_reg <= {noise_reg[23:0], noise_reg[24] ^ noise_reg[21]};
         ph_reg <= ph_reg + 3'h1;
         if (start)
         begin
            left_reg <= n_edges;
            ph_reg <= 3'h0;
         end
         else if (ph_reg == 3'h7 && left_reg != 8'h00)
            left_reg <= left_reg - 8'h01;
      end
   end
   assign busy = left_reg != 8'h00;
   // The selected clock stands low between bursts; each edge is four cycles high.
   always_comb
   begin
      clk_src_in = noise_reg[17:0];
      gate_src_in = noise_reg;
      clk_src_in[clk_code] = busy && ph_reg[2];
      gate_src_in[gate_code] = gate_level;
   end
endmodule
`default_nettype wire

// File: bench/tb_top.sv
// Self-checking bench for the gated timer: APB master, source model, comparisons.
// Assumes the source model feeds every clock and gate input of the timer.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import gstc_pkg::*;
   localparam logic [11:0] A_LO = 12'hc30;
   localparam logic [11:0] A_HI = 12'hc34;
   localparam logic [11:0] A_TC = 12'hc38;
   localparam logic [11:0] A_GC = 12'hc3c;
   localparam logic [11:0] A_GS = 12'hc40;
   localparam logic [11:0] A_CS = 12'hc44;
   localparam logic [11:0] A_ST = 12'hc60;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic start = 1'b0;
   logic glvl = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [4:0] ccode = 5'h00;
   logic [4:0] gcode = 5'h00;
   logic [7:0] nedge = 8'h00;
   logic [31:0] prdata;
   logic pready, pslverr, ovf, roll, gevt, busy, perr;
   logic [7:0] q;
   logic [17:0] csrc;
   logic [24:0] gsrc;
   logic [31:0] lfsr = 32'h8855a716;
   int err_count = 0;
   int checked = 0;
   int cyc = 0;
   gstc_timer i_gstc_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .clk_src_in(csrc), .gate_src_in(gsrc),
      .overflow_out(ovf), .rollover_flag(roll), .gate_event_flag(gevt));
   gstc_src_model i_gstc_src_model (.pclk(pclk), .presetn(presetn), .clk_code(ccode),
      .gate_code(gcode), .gate_level(glvl), .start(start), .n_edges(nedge), .busy(busy),
      .clk_src_in(csrc), .gate_src_in(gsrc));
   initial
   begin
      forever #10 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         err_count = err_count + 1;
         wrap_up();
      end
   end
   // --------------------
   // Tasks
   // --------------------
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [31:0] step(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      q = prdata[7:0];
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wrcnt(input logic [15:0] val);
      apb(1'b1, A_HI, val[15:8]);
      apb(1'b1, A_LO, val[7:0]);
   endtask
   task automatic rdcnt(output logic [15:0] val);
      logic [7:0] lo;
      apb(1'b0, A_LO, 8'h00);
      lo = q;
      apb(1'b0, A_HI, 8'h00);
      val = {q, lo};
   endtask
   task automatic edges(input logic [7:0] n);
      @(posedge pclk);
      nedge <= n;
      start <= 1'b1;
      @(posedge pclk);
      start <= 1'b0;
      @(posedge pclk);
      while (busy !== 1'b0)
         @(posedge pclk);
      repeat (12) @(posedge pclk);
   endtask
   task automatic setg(input logic l);
      glvl <= l;
      repeat (12) @(posedge pclk);
   endtask
   // --------------------
   // Scenarios
   // --------------------
   initial
   begin
      logic [15:0] v;
      logic [7:0] k;
      logic [4:0] c;
      logic e;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         apb(1'b0, A_LO + 12'(4 * i), 8'h00);
         cmp("reset value", 16'h0, {8'h0, q & (i == 3 ? 8'hfb : 8'hff)});
      end
      for (int i = 0; i < 2; i++)
      begin
         apb(1'b1, A_TC + 12'(8 * i), 8'hff);
         apb(1'b0, A_TC + 12'(8 * i), 8'h00);
         cmp("unused bits", i == 0 ? 16'h37 : 16'h1f, {8'h0, q});
      end
      apb(1'b1, 12'hc48, 8'h5a);
      apb(1'b0, 12'hc48, 8'h00);
      cmp("unmapped read", 16'h100, {7'h0, perr, q});
      for (int i = 0; i < 9; i++)
      begin
         lfsr = step(lfsr);
         k = {3'h0, lfsr[4:0]} + 8'h01;
         c = i == 8 ? 5'h0c : 5'(i + 3);
         ccode <= c;
         apb(1'b1, A_CS, {3'h0, c});
         wrcnt(16'h0);
         apb(1'b1, A_TC, {2'h0, 2'(i), 1'b0, 1'(i >> 2), 2'h1});
         edges(k);
         rdcnt(v);
         cmp("count", i == 8 ? 16'h0 : 16'(k >> (i % 4)), v);
      end
      ccode <= 5'h03;
      apb(1'b1, A_CS, 8'h03);
      for (int j = 0; j < 6; j++)
      begin
         gcode <= 5'(j + 5);
         glvl <= j[1];
         apb(1'b1, A_GS, 8'(j + 5));
         apb(1'b1, A_GC, {j != 5, j[0], 6'h0});
         apb(1'b1, A_TC, {7'h0, j != 0});
         wrcnt(16'h0);
         edges(8'h08);
         rdcnt(v);
         e = j != 0 && (j == 5 || j[0] == j[1]);
         cmp("gated count", {12'h0, e, 3'h0}, v);
         if (j[0])
         begin
            apb(1'b0, A_GC, 8'h00);
            cmp("gate view", {15'h0, j[1]}, {15'h0, q[2]});
         end
      end
      apb(1'b1, A_ST, 8'h03);
      setg(1'b1);
      setg(1'b0);
      cmp("gate event flag", 16'h1, {15'h0, gevt});
      apb(1'b1, A_ST, 8'h02);
      @(negedge pclk);
      cmp("gate event cleared", 16'h0, {15'h0, gevt});
      apb(1'b1, A_GC, 8'he0);
      apb(1'b1, A_TC, 8'h01);
      wrcnt(16'h0);
      setg(1'b1);
      setg(1'b0);
      edges(8'h06);
      apb(1'b1, A_GC, 8'hc0);
      apb(1'b1, A_GC, 8'he0);
      edges(8'h06);
      rdcnt(v);
      cmp("toggle count", 16'h6, v);
      wrcnt(16'h0);
      apb(1'b1, A_GC, 8'hd8);
      apb(1'b0, A_GC, 8'h00);
      cmp("go armed", 16'h1, {15'h0, q[3]});
      setg(1'b1);
      edges(8'h05);
      setg(1'b0);
      apb(1'b0, A_GC, 8'h00);
      cmp("go done", 16'h0, {15'h0, q[3]});
      setg(1'b1);
      edges(8'h05);
      setg(1'b0);
      rdcnt(v);
      cmp("single pulse count", 16'h5, v);
      apb(1'b1, A_GC, 8'hd8);
      apb(1'b1, A_GC, 8'hc8);
      apb(1'b0, A_GC, 8'h00);
      cmp("go cleared", 16'h0, {15'h0, q[3]});
      apb(1'b1, A_GC, 8'h00);
      apb(1'b1, A_TC, 8'h03);
      wrcnt(16'h00ff);
      apb(1'b0, A_LO, 8'h00);
      edges(8'h01);
      apb(1'b0, A_HI, 8'h00);
      cmp("buffered high", 16'h0, {8'h0, q});
      apb(1'b1, A_TC, 8'h01);
      apb(1'b0, A_HI, 8'h00);
      cmp("direct high", 16'h1, {8'h0, q});
      apb(1'b1, A_TC, 8'h03);
      wrcnt(16'hffff);
      apb(1'b1, A_ST, 8'h03);
      edges(8'h01);
      rdcnt(v);
      cmp("rolled count", 16'h0, v);
      cmp("rollover flag", 16'h1, {15'h0, roll});
      apb(1'b1, A_ST, 8'h01);
      @(negedge pclk);
      cmp("rollover cleared", 16'h0, {15'h0, roll});
      apb(1'b1, A_GC, 8'hc0);
      for (int i = 1; i < 3; i++)
      begin
         apb(1'b1, A_CS, 8'(i));
         apb(1'b1, A_TC, 8'h05);
         wrcnt(16'h0);
         setg(1'b1);
         setg(1'b0);
         rdcnt(v);
         cmp("system clock count", i == 1 ? 16'h3 : 16'hc, v);
      end
      wrap_up();
   end
endmodule
`default_nettype wire
